// [pkg/tgmsr_pkg.sv]
// Constants, register map and carrier types of the receive status register slice.
// Assumes a 32-bit register port with byte offsets and one clock domain.
package tgmsr_pkg;

   // Register byte offsets.
   localparam logic [7:0] TGMSR_OFF_UNDER_FCS   = 8'h40;
   localparam logic [7:0] TGMSR_OFF_MISS_OVER   = 8'h44;
   localparam logic [7:0] TGMSR_OFF_GAP_LEN     = 8'h48;
   localparam logic [7:0] TGMSR_OFF_CODING      = 8'h5C;
   localparam logic [7:0] TGMSR_OFF_PHY         = 8'h60;
   localparam logic [7:0] TGMSR_OFF_UDP_IP      = 8'h64;
   localparam logic [7:0] TGMSR_OFF_UDP_PORT    = 8'h68;
   localparam logic [7:0] TGMSR_OFF_TCP_IP      = 8'h80;

   // Field positions.
   localparam int TGMSR_HALF_HI_LSB   = 16;
   localparam int TGMSR_LOCK_BIT      = 0;
   localparam int TGMSR_TXDIS_BIT     = 8;
   localparam int TGMSR_OPTICAL_LSB   = 24;

   // Reset values.
   localparam logic [31:0] TGMSR_RST_WORD  = 32'h0000_0000;
   localparam logic [15:0] TGMSR_RST_COUNT = 16'h0000;

   // Frame length limits and the idle gap ceiling, in bytes.
   localparam logic [15:0] TGMSR_MIN_FRAME     = 16'h0040;
   localparam logic [15:0] TGMSR_MAX_FRAME     = 16'h05EE;
   localparam logic [15:0] TGMSR_MAX_LEN_FIELD = 16'h05DC;
   localparam logic [15:0] TGMSR_MIN_PAYLOAD   = 16'h002E;
   localparam logic [15:0] TGMSR_HDR_FCS_BYTES = 16'h0012;
   localparam logic [15:0] TGMSR_GAP_MAX       = 16'hFFFF;

   // Status FIFO geometry.
   localparam int TGMSR_FIFO_DEPTH = 16;

   // Summary of one received frame, handed over at frame end.
   typedef struct packed {
      logic        fcs_ok;
      logic [15:0] frame_bytes;
      logic [15:0] len_type;
      logic [47:0] dest_mac;
   } tgmsr_frame_t;

   localparam int TGMSR_FRAME_W = $bits(tgmsr_frame_t);

   // One register access request.
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } tgmsr_reg_req_t;

endpackage

// [verilog/tgmsr_fifo.sv]
// Synchronous FIFO with valid/ready on both sides, width and depth parameters.
// Assumes one clock and a synchronous active-low reset; depth is a power of two.
`timescale 1ns/1ns
`default_nettype none
module tgmsr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst_b,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   // Full when pointers differ only in the wrap bit.
   assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty       = (wr_ptr_r == rd_ptr_r);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign push        = i_in_valid && !full;
   assign pop         = i_out_ready && !empty;
   assign o_out_data  = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         wr_ptr_r <= '0;
      end else if (push) begin
         wr_ptr_r <= wr_ptr_r + 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rd_ptr_r <= '0;
      end else if (pop) begin
         rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule // tgmsr_fifo
`default_nettype wire

// [verilog/tgmsr_regs.sv]
// Receive status and network endpoint register slice of a 10 Gb/s Ethernet path.
// Assumes frame summaries arrive at frame end, idle byte counts per cycle, and
// a 32-bit register port with one-cycle read/write strobes, all on i_mclk.
//
// Contract
// RL1 - Frames whose frame check sequence fails are counted once each, read-only.
// RL2 - Frames shorter than the minimum valid length are counted, read-only.
// RL3 - Frames whose destination differs from the local station address are counted in the upper half of 0x44.
// RL4 - Frames longer than the maximum valid length are counted in the lower half of 0x44.
// RL5 - Frames whose length field disagrees with the received length are counted in the lower half of 0x48.
// RL6 - The idle gap between received packets is measured in bytes and shown in the upper half of 0x48.
// RL7 - Bit zero of the coding core byte shows block lock and bits seven to one read zero.
// RL8 - The transmit-disable request of the coding core is shown read-only in bit eight.
// RL9 - The optical module state sits in the top byte of 0x60 and the PHY identity in its lower half.
// RL10 - A writable 32-bit word at 0x64 is the UDP server IPv4 address, first byte in bits 31 to 24.
// RL11 - The lower half of the UDP port word is the writable remote UDP port.
// RL12 - The upper half of the UDP port word is the writable local UDP source port.
// RL13 - A writable 32-bit word at 0x80 is the TCP server IPv4 address, first byte in bits 31 to 24.
// RL14 - Each 16-bit frame counter adds one per qualifying frame, wraps to zero and ignores writes.
`timescale 1ns/1ns
`default_nettype none
module tgmsr_regs
   import tgmsr_pkg::*;
(
   input  wire logic            i_mclk,
   input  wire logic            i_rst_b,
   // Register port.
   input  wire tgmsr_reg_req_t  i_reg_req,
   output logic [31:0]          o_reg_rdata,
   output logic                 o_reg_ack,
   // Frame summaries from the receive path.
   input  wire logic            i_frm_valid,
   output logic                 o_frm_ready,
   input  wire tgmsr_frame_t    i_frm_data,
   input  wire logic [47:0]     i_local_mac,
   // Line activity for the gap measurement.
   input  wire logic            i_rx_active,
   input  wire logic [3:0]      i_rx_idle_bytes,
   // Coding layer and PHY state.
   input  wire logic            i_block_lock,
   input  wire logic            i_tx_disable_req,
   input  wire logic [15:0]     i_phy_ident,
   input  wire logic [7:0]      i_optical_module_state,
   // Endpoint settings.
   output logic [31:0]          o_udp_server_ip,
   output logic [15:0]          o_udp_remote_port,
   output logic [15:0]          o_udp_source_port,
   output logic [31:0]          o_tcp_server_ip
);

   tgmsr_frame_t frm_head;
   logic         frm_avail;
   logic         frm_take;

   logic [15:0]  rx_fcs_fail_count_r;
   logic [15:0]  rx_undersize_count_r;
   logic [15:0]  rx_addr_miss_count_r;
   logic [15:0]  rx_oversize_count_r;
   logic [15:0]  rx_len_mismatch_count_r;
   logic [15:0]  rx_gap_bytes_r;
   logic [15:0]  gap_accum_r;
   logic [15:0]  gap_accum_nxt;
   logic         rx_active_r;

   logic         coding_lock_r;
   logic         tx_disable_r;
   logic [15:0]  phy_ident_r;
   logic [7:0]   optical_module_state_r;

   logic [31:0]  udp_server_ip_r;
   logic [31:0]  udp_port_pair_r;
   logic [31:0]  tcp_server_ip_r;

   logic [15:0]  expect_payload;
   logic         is_undersize;
   logic         is_oversize;
   logic         is_addr_miss;
   logic         is_len_mismatch;

   logic [31:0]  rdata_nxt;

   // Frame summaries queue up here so that bursts of short frames are not lost
   // while the counters are held still during a register read.
   tgmsr_fifo #(
      .WIDTH (TGMSR_FRAME_W),
      .DEPTH (TGMSR_FIFO_DEPTH)
   ) u_frm_fifo (
      .i_mclk      (i_mclk),
      .i_rst_b     (i_rst_b),
      .i_in_valid  (i_frm_valid),
      .o_in_ready  (o_frm_ready),
      .i_in_data   (i_frm_data),
      .o_out_valid (frm_avail),
      .i_out_ready (frm_take),
      .o_out_data  (frm_head)
   );

   // Draining pauses on a read so the word returned is one consistent snapshot.
   assign frm_take = frm_avail && !i_reg_req.rd;

   // Padded frames carry a short length field; the payload then is the minimum.
   always_comb begin
      if (frm_head.len_type < TGMSR_MIN_PAYLOAD) begin
         expect_payload = TGMSR_MIN_PAYLOAD;
      end else begin
         expect_payload = frm_head.len_type;
      end
   end

   assign is_undersize    = frm_head.frame_bytes < TGMSR_MIN_FRAME;   // [RL2]
   assign is_oversize     = frm_head.frame_bytes > TGMSR_MAX_FRAME;   // [RL4]
   assign is_addr_miss    = frm_head.dest_mac != i_local_mac;         // [RL3]
   // Values above the length limit are type codes and are never checked.
   assign is_len_mismatch = (frm_head.len_type <= TGMSR_MAX_LEN_FIELD) &&
                            !is_undersize &&
                            (expect_payload != frm_head.frame_bytes - TGMSR_HDR_FCS_BYTES); // [RL5]

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rx_fcs_fail_count_r <= TGMSR_RST_COUNT;
      end else if (frm_take && !frm_head.fcs_ok) begin
         rx_fcs_fail_count_r <= rx_fcs_fail_count_r + 16'h0001; // [RL1] [RL14]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rx_undersize_count_r <= TGMSR_RST_COUNT;
      end else if (frm_take && is_undersize) begin
         rx_undersize_count_r <= rx_undersize_count_r + 16'h0001; // [RL2] [RL14]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rx_addr_miss_count_r <= TGMSR_RST_COUNT;
      end else if (frm_take && is_addr_miss) begin
         rx_addr_miss_count_r <= rx_addr_miss_count_r + 16'h0001; // [RL3] [RL14]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rx_oversize_count_r <= TGMSR_RST_COUNT;
      end else if (frm_take && is_oversize) begin
         rx_oversize_count_r <= rx_oversize_count_r + 16'h0001; // [RL4] [RL14]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rx_len_mismatch_count_r <= TGMSR_RST_COUNT;
      end else if (frm_take && is_len_mismatch) begin
         rx_len_mismatch_count_r <= rx_len_mismatch_count_r + 16'h0001; // [RL5] [RL14]
      end
   end

   // The gap accumulator saturates so a long idle line never reads as a short gap.
   always_comb begin
      if (gap_accum_r > TGMSR_GAP_MAX - {12'h000, i_rx_idle_bytes}) begin
         gap_accum_nxt = TGMSR_GAP_MAX;
      end else begin
         gap_accum_nxt = gap_accum_r + {12'h000, i_rx_idle_bytes};
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rx_active_r <= 1'b0;
      end else begin
         rx_active_r <= i_rx_active;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         gap_accum_r <= TGMSR_RST_COUNT;
      end else if (i_rx_active && !rx_active_r) begin
         gap_accum_r <= TGMSR_RST_COUNT;
      end else if (!i_rx_active) begin
         gap_accum_r <= gap_accum_nxt; // [RL6]
      end
   end

   // The gap is latched at the start of the next packet.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rx_gap_bytes_r <= TGMSR_RST_COUNT;
      end else if (i_rx_active && !rx_active_r) begin
         rx_gap_bytes_r <= gap_accum_r; // [RL6]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         coding_lock_r <= 1'b0;
         tx_disable_r  <= 1'b0;
      end else begin
         coding_lock_r <= i_block_lock;     // [RL7]
         tx_disable_r  <= i_tx_disable_req; // [RL8]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         phy_ident_r            <= 16'h0000;
         optical_module_state_r <= 8'h00;
      end else begin
         phy_ident_r            <= i_phy_ident;            // [RL9]
         optical_module_state_r <= i_optical_module_state; // [RL9]
      end
   end

   // Endpoint settings take whole-word writes only; the port has no byte lanes.
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         udp_server_ip_r <= TGMSR_RST_WORD;
      end else if (i_reg_req.wr && i_reg_req.addr == TGMSR_OFF_UDP_IP) begin
         udp_server_ip_r <= i_reg_req.wdata; // [RL10]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         udp_port_pair_r <= TGMSR_RST_WORD;
      end else if (i_reg_req.wr && i_reg_req.addr == TGMSR_OFF_UDP_PORT) begin
         udp_port_pair_r <= i_reg_req.wdata; // [RL11] [RL12]
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         tcp_server_ip_r <= TGMSR_RST_WORD;
      end else if (i_reg_req.wr && i_reg_req.addr == TGMSR_OFF_TCP_IP) begin
         tcp_server_ip_r <= i_reg_req.wdata; // [RL13]
      end
   end

   assign o_udp_server_ip   = udp_server_ip_r;
   assign o_udp_remote_port = udp_port_pair_r[TGMSR_HALF_HI_LSB-1:0];  // [RL11]
   assign o_udp_source_port = udp_port_pair_r[31:TGMSR_HALF_HI_LSB];   // [RL12]
   assign o_tcp_server_ip   = tcp_server_ip_r;

   // Read decode; counters and status words ignore writes, unmapped reads give zero.
   always_comb begin
      rdata_nxt = TGMSR_RST_WORD;
      case (i_reg_req.addr)
         TGMSR_OFF_UNDER_FCS: begin
            rdata_nxt = {rx_undersize_count_r, rx_fcs_fail_count_r}; // [RL1] [RL2]
         end
         TGMSR_OFF_MISS_OVER: begin
            rdata_nxt = {rx_addr_miss_count_r, rx_oversize_count_r}; // [RL3] [RL4]
         end
         TGMSR_OFF_GAP_LEN: begin
            rdata_nxt = {rx_gap_bytes_r, rx_len_mismatch_count_r}; // [RL5] [RL6]
         end
         TGMSR_OFF_CODING: begin
            rdata_nxt[TGMSR_LOCK_BIT]  = coding_lock_r; // [RL7]
            rdata_nxt[TGMSR_TXDIS_BIT] = tx_disable_r;  // [RL8]
         end
         TGMSR_OFF_PHY: begin
            rdata_nxt[31:TGMSR_OPTICAL_LSB]    = optical_module_state_r; // [RL9]
            rdata_nxt[TGMSR_HALF_HI_LSB-1:0]   = phy_ident_r;            // [RL9]
         end
         TGMSR_OFF_UDP_IP: begin
            rdata_nxt = udp_server_ip_r;
         end
         TGMSR_OFF_UDP_PORT: begin
            rdata_nxt = udp_port_pair_r;
         end
         TGMSR_OFF_TCP_IP: begin
            rdata_nxt = tcp_server_ip_r;
         end
         default: begin
            rdata_nxt = TGMSR_RST_WORD;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_reg_rdata <= TGMSR_RST_WORD;
      end else if (i_reg_req.rd) begin
         o_reg_rdata <= rdata_nxt;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_reg_ack <= 1'b0;
      end else begin
         o_reg_ack <= i_reg_req.rd || i_reg_req.wr;
      end
   end

endmodule // tgmsr_regs
`default_nettype wire

// [test/tgmsr_regs_chk.sv]
// Concurrent checks on the register port and endpoint outputs of the status slice.
// Assumes it is bound into tgmsr_regs and shares its single clock and reset.
`timescale 1ns/1ns
`default_nettype none
module tgmsr_regs_chk
   import tgmsr_pkg::*;
(
   input wire logic           i_mclk,
   input wire logic           i_rst_b,
   input wire tgmsr_reg_req_t i_reg_req,
   input wire logic [31:0]    o_reg_rdata,
   input wire logic           o_reg_ack,
   input wire logic           i_block_lock,
   input wire logic           i_tx_disable_req,
   input wire logic [15:0]    i_phy_ident,
   input wire logic [7:0]     i_optical_module_state,
   input wire logic [31:0]    o_udp_server_ip,
   input wire logic [15:0]    o_udp_remote_port,
   input wire logic [15:0]    o_udp_source_port,
   input wire logic [31:0]    o_tcp_server_ip
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_wr(logic [7:0] a);
      i_reg_req.wr && i_reg_req.addr == a;
   endsequence

   // Status reads are judged only on steady inputs, so the input register delay is moot.
   sequence s_rd_steady(logic [7:0] a);
      i_reg_req.rd && i_reg_req.addr == a && $stable(i_block_lock) && $stable(i_tx_disable_req)
      && $stable(i_phy_ident) && $stable(i_optical_module_state);
   endsequence

   a_ack_follows: assert property ((i_reg_req.rd || i_reg_req.wr) |=> o_reg_ack)
      else $error("no acknowledge after a request");
   a_ack_has_cause: assert property (o_reg_ack |-> $past(i_reg_req.rd) || $past(i_reg_req.wr))
      else $error("acknowledge without a request");
   a_udp_ip_write: assert property (s_wr(TGMSR_OFF_UDP_IP) |=> o_udp_server_ip == $past(i_reg_req.wdata))
      else $error("UDP server address not taken from write");
   a_udp_ip_hold: assert property (!(i_reg_req.wr && i_reg_req.addr == TGMSR_OFF_UDP_IP) |=> $stable(o_udp_server_ip))
      else $error("UDP server address changed without a write");
   a_udp_port_pair: assert property (s_wr(TGMSR_OFF_UDP_PORT) |=> {o_udp_source_port, o_udp_remote_port} == $past(i_reg_req.wdata))
      else $error("UDP port halves not taken from write");
   a_tcp_ip_write: assert property (s_wr(TGMSR_OFF_TCP_IP) |=> o_tcp_server_ip == $past(i_reg_req.wdata))
      else $error("TCP server address not taken from write");
   a_coding_read: assert property (s_rd_steady(TGMSR_OFF_CODING) |=> o_reg_rdata == {23'h0, $past(i_tx_disable_req), 7'h00, $past(i_block_lock)})
      else $error("coding state word wrong");
   a_phy_read: assert property (s_rd_steady(TGMSR_OFF_PHY) |=> o_reg_rdata == {$past(i_optical_module_state), 8'h00, $past(i_phy_ident)})
      else $error("PHY state word wrong");
endmodule // tgmsr_regs_chk

bind tgmsr_regs tgmsr_regs_chk u_chk (
   .i_mclk                 (i_mclk),
   .i_rst_b                (i_rst_b),
   .i_reg_req              (i_reg_req),
   .o_reg_rdata            (o_reg_rdata),
   .o_reg_ack              (o_reg_ack),
   .i_block_lock           (i_block_lock),
   .i_tx_disable_req       (i_tx_disable_req),
   .i_phy_ident            (i_phy_ident),
   .i_optical_module_state (i_optical_module_state),
   .o_udp_server_ip        (o_udp_server_ip),
   .o_udp_remote_port      (o_udp_remote_port),
   .o_udp_source_port      (o_udp_source_port),
   .o_tcp_server_ip        (o_tcp_server_ip)
);
`default_nettype wire

// [test/tgmsr_phy_model.sv]
// Behavioural far side of the receive path: frame summaries, line gaps and PHY levels.
// Assumes the bench calls its tasks from one process at a time per task kind.
`timescale 1ns/1ns
`default_nettype none
module tgmsr_phy_model
   import tgmsr_pkg::*;
(
   input  wire logic     i_mclk,
   input  wire logic     i_frm_ready,
   output var tgmsr_frame_t o_frm_data,
   output logic          o_frm_valid,
   output logic          o_rx_active,
   output logic [3:0]    o_rx_idle_bytes,
   output logic          o_block_lock,
   output logic          o_tx_disable_req,
   output logic [15:0]   o_phy_ident,
   output logic [7:0]    o_optical_module_state,
   output logic [47:0]   o_local_mac
);
   int stall_cycles;
   initial begin
      o_frm_data = '0;
      o_frm_valid = 1'b0;
      o_rx_active = 1'b1;
      o_rx_idle_bytes = 4'h0;
      o_block_lock = 1'b0;
      o_tx_disable_req = 1'b0;
      o_phy_ident = 16'h0000;
      o_optical_module_state = 8'h00;
      o_local_mac = 48'h02005E102030;
      stall_cycles = 0;
   end

   // Ready is sampled at the falling edge because it only moves on rising edges.
   task automatic send(input tgmsr_frame_t f, output logic ok);
      int n;
      ok = 1'b0;
      n = 0;
      @(posedge i_mclk);
      o_frm_valid <= 1'b1;
      o_frm_data  <= f;
      while (!ok && n < 300) begin
         @(negedge i_mclk);
         ok = i_frm_ready;
         if (!ok) stall_cycles++;
         n++;
         @(posedge i_mclk);
      end
      o_frm_valid <= 1'b0;
      o_frm_data  <= ~f;
   endtask

   task automatic idle_gap(input int cycles, input logic [3:0] per_cycle);
      @(posedge i_mclk);
      o_rx_active     <= 1'b0;
      o_rx_idle_bytes <= per_cycle;
      repeat (cycles) @(posedge i_mclk);
      o_rx_active     <= 1'b1;
      o_rx_idle_bytes <= ~per_cycle;
   endtask

   task automatic set_status(input logic lk, input logic td, input logic [15:0] id,
                             input logic [7:0] om);
      @(posedge i_mclk);
      o_block_lock           <= lk;
      o_tx_disable_req       <= td;
      o_phy_ident            <= id;
      o_optical_module_state <= om;
   endtask
endmodule // tgmsr_phy_model
`default_nettype wire

// [test/tgmsr_regs_tb.sv]
// Self-checking bench of the status register slice with a behavioural far side.
// Assumes one-cycle read/write strobes answered by an acknowledge one cycle later.
`timescale 1ns/1ns
`default_nettype none
module tgmsr_regs_tb
   import tgmsr_pkg::*;
;
   logic           i_mclk;
   logic           i_rst_b;
   tgmsr_reg_req_t req;
   tgmsr_frame_t   frm;
   logic [31:0]    rdata, udp_ip, tcp_ip;
   logic [15:0]    rport, sport, ident, e_fcs, e_und, e_miss, e_over, e_len;
   logic [47:0]    mac;
   logic [7:0]     opt;
   logic [3:0]     idle;
   logic           ack, fvalid, fready, active, lock, txd;
   int             bad_count, total_checks;
   logic [7:0]     offs [9] = '{TGMSR_OFF_UNDER_FCS, TGMSR_OFF_MISS_OVER, TGMSR_OFF_GAP_LEN,
      TGMSR_OFF_CODING, TGMSR_OFF_PHY, TGMSR_OFF_UDP_IP, TGMSR_OFF_UDP_PORT, TGMSR_OFF_TCP_IP, 8'hFC};

   tgmsr_regs uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reg_req(req), .o_reg_rdata(rdata),
      .o_reg_ack(ack), .i_frm_valid(fvalid), .o_frm_ready(fready), .i_frm_data(frm),
      .i_local_mac(mac), .i_rx_active(active), .i_rx_idle_bytes(idle), .i_block_lock(lock),
      .i_tx_disable_req(txd), .i_phy_ident(ident), .i_optical_module_state(opt),
      .o_udp_server_ip(udp_ip), .o_udp_remote_port(rport), .o_udp_source_port(sport),
      .o_tcp_server_ip(tcp_ip));
   tgmsr_phy_model u_phy (.i_mclk(i_mclk), .i_frm_ready(fready), .o_frm_data(frm),
      .o_frm_valid(fvalid), .o_rx_active(active), .o_rx_idle_bytes(idle), .o_block_lock(lock),
      .o_tx_disable_req(txd), .o_phy_ident(ident), .o_optical_module_state(opt),
      .o_local_mac(mac));

   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      total_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] %0t %s: seen %h want %h", $time, what, seen, want);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_mclk);
      req <= '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge i_mclk);
      req <= '0;
      @(negedge i_mclk);
      while (ack !== 1'b1 && n < 8) begin
         @(negedge i_mclk);
         n++;
      end
      check(n < 8, 1'b1, "acknowledge missing");
      if (n == 8) final_report();
      q = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, q);
      check(q, want, "register read");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask

   // Expected counts come from the classification, never from the design.
   task automatic frame(input logic f, input logic [15:0] b, input logic [15:0] l, input logic m);
      logic ok;
      u_phy.send('{fcs_ok: f, frame_bytes: b, len_type: l, dest_mac: m ? mac : ~mac}, ok);
      check(ok, 1'b1, "frame refused");
      if (!ok) final_report();
      if (!f) e_fcs++;
      if (b < 16'h0040) e_und++;
      if (b > 16'h05EE) e_over++;
      if (!m) e_miss++;
      if (l <= 16'h05DC && b >= 16'h0040 && ((l < 16'h002E) ? 16'h002E : l) != b - 16'h0012) e_len++;
   endtask

   initial begin
      req = '0;
      i_rst_b = 1'b0;
      bad_count = 0;
      total_checks = 0;
      {e_fcs, e_und, e_miss, e_over, e_len} = '0;
      repeat (10) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      for (int i = 0; i < 9; i++) rd_chk(offs[i], TGMSR_RST_WORD);
      check(udp_ip | tcp_ip | {sport, rport}, TGMSR_RST_WORD, "endpoint reset");
      wr(8'hFC, 32'hFFFFFFFF);
      rd_chk(8'hFC, 32'h0);
      $display("test reset values done");
      wr(TGMSR_OFF_UDP_IP, 32'hC0A80A01);
      wr(TGMSR_OFF_UDP_PORT, 32'h1234ABCD);
      wr(TGMSR_OFF_TCP_IP, 32'h0A000002);
      rd_chk(TGMSR_OFF_UDP_IP, 32'hC0A80A01);
      rd_chk(TGMSR_OFF_UDP_PORT, 32'h1234ABCD);
      rd_chk(TGMSR_OFF_TCP_IP, 32'h0A000002);
      check(udp_ip, 32'hC0A80A01, "UDP address");
      check(rport, 16'hABCD, "UDP remote port");
      check(sport, 16'h1234, "UDP source port");
      check(tcp_ip, 32'h0A000002, "TCP address");
      $display("test endpoints done");
      for (int i = 0; i < 4; i++) begin
         u_phy.set_status(i[0], i[1], 16'hA5C3 ^ i[15:0], 8'h5A ^ i[7:0]);
         repeat (3) @(posedge i_mclk);
         rd_chk(TGMSR_OFF_CODING, {23'h0, i[1], 7'h0, i[0]});
         rd_chk(TGMSR_OFF_PHY, {8'h5A ^ i[7:0], 8'h00, 16'hA5C3 ^ i[15:0]});
      end
      $display("test status done");
      frame(1'b1, 16'h0040, 16'h002E, 1'b1);
      frame(1'b1, 16'h003F, 16'h0800, 1'b1);
      frame(1'b0, 16'h05EE, 16'h05DC, 1'b1);
      frame(1'b1, 16'h05EF, 16'h0800, 1'b0);
      frame(1'b1, 16'h0064, 16'h0032, 1'b1);
      frame(1'b1, 16'h0040, 16'h000A, 1'b1);
      frame(1'b0, 16'h0028, 16'h0014, 1'b0);
      repeat (5) @(posedge i_mclk);
      rd_chk(TGMSR_OFF_UNDER_FCS, {e_und, e_fcs});
      rd_chk(TGMSR_OFF_MISS_OVER, {e_miss, e_over});
      rd_chk(TGMSR_OFF_GAP_LEN, {16'h0000, e_len});
      wr(TGMSR_OFF_MISS_OVER, 32'hFFFFFFFF);
      rd_chk(TGMSR_OFF_MISS_OVER, {e_miss, e_over});
      $display("test frame counters done");
      u_phy.idle_gap(5, 4'h8);
      repeat (3) @(posedge i_mclk);
      rd_chk(TGMSR_OFF_GAP_LEN, {16'h0028, e_len});
      u_phy.idle_gap(3, 4'hF);
      repeat (3) @(posedge i_mclk);
      rd_chk(TGMSR_OFF_GAP_LEN, {16'h002D, e_len});
      // A long idle line must pin the gap at its ceiling rather than wrap.
      u_phy.idle_gap(4400, 4'hF);
      repeat (3) @(posedge i_mclk);
      rd_chk(TGMSR_OFF_GAP_LEN, {16'hFFFF, e_len});
      $display("test gap done");
      // Back-to-back reads stall the drain, so the buffer fills and must push back.
      fork
         begin
            @(posedge i_mclk);
            req <= '{rd: 1'b1, wr: 1'b0, addr: TGMSR_OFF_MISS_OVER, wdata: 32'h0};
            repeat (40) @(posedge i_mclk);
            req <= '0;
         end
         for (int i = 0; i < 18; i++) frame(1'b1, 16'h0100, 16'h0800, 1'b0);
      join
      check(u_phy.stall_cycles > 0, 1'b1, "no back-pressure");
      repeat (30) @(posedge i_mclk);
      rd_chk(TGMSR_OFF_MISS_OVER, {e_miss, e_over});
      $display("test buffer fill done");
      @(posedge i_mclk);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      rd_chk(TGMSR_OFF_MISS_OVER, TGMSR_RST_WORD);
      check(udp_ip | tcp_ip, TGMSR_RST_WORD, "endpoint reset");
      $display("test mid-run reset done");
      final_report();
   end
endmodule // tgmsr_regs_tb
`default_nettype wire
